// ==== hw/hsp_pkg.sv ====
// Shared constants, types and helpers of the host slave port
package hsp_pkg;
	// Core clock
	localparam int unsigned CLK_MHZ = 250;
	// Register offsets on the local register port
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_PAGE = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;
	// Field positions in port_config_reg
	localparam int unsigned CFG_WIDE_BIT = 0;
	localparam int unsigned CFG_ACC_BIT = 1;
	localparam int unsigned CFG_POL_BIT = 5;
	localparam int unsigned CFG_ACKF_LO = 6;
	localparam int unsigned CFG_ACKF_HI = 7;
	// Field positions in the status register
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_WAIT_BIT = 1;
	localparam int unsigned STAT_STRAP_BIT = 2;
	// Reset values
	localparam logic [1:0] ACKF_RESET = 2'h0;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	// Clocks after reset release before the straps are taken
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// Page decode for the memory selects
	localparam logic [7:0] PAGE_INT_LAST = 8'h00;
	localparam logic [7:0] PAGE_BOOT_FIRST = 8'hf0;
	// Memory select bit positions
	localparam int unsigned SEL_INT = 0;
	localparam int unsigned SEL_EXT = 1;
	localparam int unsigned SEL_BOOT = 2;
	localparam int unsigned SEL_IO = 3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01,
		ST_HOLD = 2'b10
	} hsp_state_e;

	// Host transfers that make one internal word
	function automatic logic [1:0] hsp_pieces(input logic io, input logic wide);
		if (io)
			return wide ? 2'h1 : 2'h2;
		return wide ? 2'h2 : 2'h3;
	endfunction

	// Memory select from space and target page
	function automatic logic [3:0] hsp_decode(input logic io, input logic [7:0] page);
		logic [3:0] s;
		s = 4'h0;
		if (io)
			s[SEL_IO] = 1'b1;
		else if (page <= PAGE_INT_LAST)
			s[SEL_INT] = 1'b1;
		else if (page >= PAGE_BOOT_FIRST)
			s[SEL_BOOT] = 1'b1;
		else
			s[SEL_EXT] = 1'b1;
		return s;
	endfunction
endpackage

// ==== hw/hsp_pack_if.sv ====
// Carrier between the port controller and the word packer
`timescale 1ns/1ps
interface hsp_pack_if;
	logic push;
	logic load;
	logic wide;
	logic [1:0] idx;
	logic [15:0] piece_in;
	logic [23:0] word_in;
	logic [23:0] word;
	logic [15:0] piece_out;
	modport ctl (output push, load, wide, idx, piece_in, word_in, input word, piece_out);
	modport pk (input push, load, wide, idx, piece_in, word_in, output word, piece_out);
endinterface

// ==== hw/hsp_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hsp_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only once stages two and three agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_level <= '0;
		else
			o_level <= (s2_q & s3_q) | (o_level & (s2_q | s3_q));
	end
endmodule

// ==== hw/hsp_pack.sv ====
// Packs host pieces into one 24-bit word and splits it back
`timescale 1ns/1ps
module hsp_pack (
	input wire logic i_clk,
	input wire logic i_rst_n,
	hsp_pack_if.pk p
);
	logic [23:0] buf_q;
	logic [5:0] sh;
	logic [31:0] placed;
	logic [31:0] shifted;

	always_comb begin
		sh = p.wide ? {p.idx, 4'h0} : {1'b0, p.idx, 3'h0};
		placed = {16'h0000, p.wide ? p.piece_in : {8'h00, p.piece_in[7:0]}} << sh;
		shifted = {8'h00, buf_q} >> sh;
	end

	// First piece of a word clears the rest
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			buf_q <= 24'h000000;
		else if (p.load)
			buf_q <= p.word_in;
		else if (p.push)
			buf_q <= (p.idx == 2'h0) ? placed[23:0] : (buf_q | placed[23:0]);
	end

	assign p.word = buf_q;
	assign p.piece_out = p.wide ? shifted[15:0] : {8'h00, shifted[7:0]};
endmodule

// ==== hw/hsp_port.sv ====
// Host slave port: strobes, address modes, acknowledge and word packing
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RULE1 - Slave lets host reach memory, boot, I/O
// RULE2 - Multiplexed asynchronous bus, 8 or 16 bits
// RULE3 - Internal access steals one core cycle
// RULE4 - Address auto-increments after every word
// RULE5 - Equal straps give ready mode bit
// RULE6 - Upper mode bit cleared; both bits writable
// RULE7 - Polarity strapped at reset, read only
// RULE8 - Address mode detected from latch, write
// RULE9 - Read completes with data, no write
// RULE10 - Write completes with room, no write
// RULE11 - Ack mode: ack, strobe drops, ack drops
// RULE12 - Ready mode: ready low inserts waits
// RULE13 - Host holds strobe until ready seen
// RULE14 - Address cycles always acknowledged in cycle mode
// RULE15 - Memory and I/O chip selects, active low
// RULE16 - Host sets width and page first
// RULE17 - Memory selects decoded from target address
// RULE18 - One to three transfers per word
// RULE19 - Mid-word pieces acknowledged at once
// RULE20 - Low polarity inverts every ack level
module hsp_port (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_host_ad,
	output logic [15:0] o_host_ad,
	output logic o_host_ad_oe,
	input wire logic i_host_addr_latch_in,
	input wire logic i_host_write_strobe_n,
	input wire logic i_host_read_strobe_n,
	input wire logic i_mem_space_select_n,
	input wire logic i_io_space_select_n,
	input wire logic i_ack_polarity_strap,
	input wire logic i_host_ack_ready_in,
	output logic o_host_ack_ready_out,
	output logic o_host_ack_ready_oe,
	output logic o_dma_req,
	output logic o_dma_we,
	output logic [23:0] o_dma_addr,
	output logic [23:0] o_dma_wdata,
	output logic [3:0] o_mem_sel,
	input wire logic i_dma_done,
	input wire logic [23:0] i_dma_rdata,
	output logic o_core_steal,
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata
);
	logic [15:0] ad_s;
	logic ale_s;
	logic wr_s;
	logic rd_s;
	logic mcs_s;
	logic iocs_s;
	logic pol_s;
	logic ackin_s;
	logic [22:0] pins_s;
	logic strb;
	logic strb_q;
	logic strb_rise;
	logic ale_q;
	logic cs;
	logic [1:0] ackf_q;
	logic pol_q;
	logic wide_q;
	logic acc_q;
	logic [7:0] page_q;
	logic [2:0] settle_q;
	logic strap_done_q;
	logic [15:0] addr_q;
	logic we_q;
	logic [1:0] idx_q;
	logic [1:0] need;
	logic last;
	logic addr_cycle;
	logic [15:0] ad_out_q;
	logic [3:0] sel_q;
	logic ack_level;
	hsp_pkg::hsp_state_e state_q;

	hsp_pack_if pk_if ();

	hsp_sync #(
		.W(23)
	) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pin({i_host_ad, i_host_addr_latch_in, ~i_host_write_strobe_n, ~i_host_read_strobe_n,
			~i_mem_space_select_n, ~i_io_space_select_n, i_ack_polarity_strap, i_host_ack_ready_in}),
		.o_level(pins_s)
	);

	hsp_pack u_pack (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.p(pk_if.pk)
	);

	assign {ad_s, ale_s, wr_s, rd_s, mcs_s, iocs_s, pol_s, ackin_s} = pins_s;

	// Port is selected by either chip select
	assign cs = mcs_s | iocs_s; // RULE15
	assign strb = cs & (wr_s | rd_s);
	assign strb_rise = strb & ~strb_q;
	// Address cycle: latch high under a strobe in cycle mode, detecting cycle included
	assign addr_cycle = ale_s & (acc_q | (~ale_q & wr_s));
	// Piece count of the space selected by the strobe being taken
	assign need = hsp_pkg::hsp_pieces(iocs_s, wide_q); // RULE18
	assign last = (idx_q == need - 2'h1);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strb_q <= 1'b0;
			ale_q <= 1'b0;
		end else begin
			strb_q <= strb;
			ale_q <= ale_s;
		end
	end

	// Straps taken once the synchronisers have filled after release
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_q <= 3'h0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			settle_q <= settle_q + 3'h1;
			strap_done_q <= (settle_q == hsp_pkg::STRAP_SETTLE);
		end
	end

	// Acknowledge function bits and polarity
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ackf_q <= hsp_pkg::ACKF_RESET; // RULE6
			pol_q <= 1'b0;
		end else if (!strap_done_q && settle_q == hsp_pkg::STRAP_SETTLE) begin
			ackf_q[0] <= (pol_s == ackin_s); // RULE5
			ackf_q[1] <= 1'b0; // RULE6
			pol_q <= pol_s; // RULE7
		end else if (i_reg_wr && i_reg_addr == hsp_pkg::REG_CFG) begin
			ackf_q <= i_reg_wdata[hsp_pkg::CFG_ACKF_HI:hsp_pkg::CFG_ACKF_LO]; // RULE6
		end
	end

	// Bus width and target page
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wide_q <= 1'b0;
			page_q <= hsp_pkg::PAGE_RESET;
		end else if (i_reg_wr) begin
			if (i_reg_addr == hsp_pkg::REG_CFG)
				wide_q <= i_reg_wdata[hsp_pkg::CFG_WIDE_BIT]; // RULE2
			if (i_reg_addr == hsp_pkg::REG_PAGE)
				page_q <= i_reg_wdata[7:0];
		end
	end

	// Address mode: latch pulse with write strobe active means cycle mode
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			acc_q <= 1'b0;
		else if (ale_s && !ale_q)
			acc_q <= wr_s; // RULE8
	end

	// Address: latched on the falling latch edge in latch mode, or in an address cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= hsp_pkg::ADDR_RESET;
		end else if (!acc_q && ale_q && !ale_s) begin
			addr_q <= ad_s; // RULE8
		end else if (state_q == hsp_pkg::ST_IDLE && strb_rise && addr_cycle) begin
			addr_q <= ad_s;
		end else if (state_q == hsp_pkg::ST_MEM && i_dma_done) begin
			addr_q <= addr_q + 16'h0001; // RULE4
		end
	end

	// Piece index restarts on a new address
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= 2'h0;
		end else if ((!acc_q && ale_q && !ale_s) || (state_q == hsp_pkg::ST_IDLE && strb_rise && addr_cycle)) begin
			idx_q <= 2'h0;
		end else if (state_q == hsp_pkg::ST_IDLE && strb_rise) begin
			idx_q <= last ? 2'h0 : idx_q + 2'h1; // RULE18
		end
	end

	// Transfer sequencing
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= hsp_pkg::ST_IDLE;
			we_q <= 1'b0;
		end else begin
			case (state_q)
				hsp_pkg::ST_IDLE: begin
					if (strb_rise && strap_done_q) begin
						we_q <= wr_s; // RULE1
						if (addr_cycle)
							state_q <= hsp_pkg::ST_HOLD; // RULE14
						else if (wr_s && last)
							state_q <= hsp_pkg::ST_MEM; // RULE10
						else if (rd_s && idx_q == 2'h0)
							state_q <= hsp_pkg::ST_MEM; // RULE9
						else
							state_q <= hsp_pkg::ST_HOLD; // RULE19
					end
				end
				hsp_pkg::ST_MEM: begin
					if (i_dma_done)
						state_q <= hsp_pkg::ST_HOLD;
				end
				hsp_pkg::ST_HOLD: begin
					if (!strb)
						state_q <= hsp_pkg::ST_IDLE; // RULE11
				end
				default: begin
					state_q <= hsp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Packer control
	assign pk_if.wide = wide_q;
	assign pk_if.idx = idx_q;
	assign pk_if.piece_in = ad_s;
	assign pk_if.push = state_q == hsp_pkg::ST_IDLE && strb_rise && strap_done_q && wr_s && !addr_cycle;
	assign pk_if.word_in = i_dma_rdata;
	assign pk_if.load = state_q == hsp_pkg::ST_MEM && i_dma_done && !we_q; // RULE18

	// Read piece loaded on the edge that enters HOLD, so data stand from the same edge as the ack
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ad_out_q <= 16'h0000;
		else if (state_q == hsp_pkg::ST_MEM && i_dma_done && !we_q)
			ad_out_q <= wide_q ? i_dma_rdata[15:0] : {8'h00, i_dma_rdata[7:0]}; // RULE9
		else if (state_q == hsp_pkg::ST_IDLE && strb_rise && strap_done_q && rd_s && !addr_cycle
			&& idx_q != 2'h0)
			ad_out_q <= pk_if.piece_out; // RULE19
	end

	// Memory select latched per access
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			sel_q <= 4'h0;
		else if (state_q == hsp_pkg::ST_IDLE && strb_rise)
			sel_q <= hsp_pkg::hsp_decode(iocs_s, page_q); // RULE17
	end

	always_comb begin
		o_dma_req = state_q == hsp_pkg::ST_MEM;
		o_dma_we = we_q;
		o_dma_addr = {page_q, addr_q}; // RULE17
		o_dma_wdata = pk_if.word;
		o_mem_sel = (state_q == hsp_pkg::ST_MEM) ? sel_q : 4'h0;
		// External accesses leave the core running
		o_core_steal = o_dma_req && i_dma_done && sel_q[hsp_pkg::SEL_INT]; // RULE3
	end

	// Read data driven only under a read strobe with the port selected
	assign o_host_ad = ad_out_q;
	assign o_host_ad_oe = rd_s && cs && state_q == hsp_pkg::ST_HOLD && !addr_cycle; // RULE2

	// Active-high acknowledge level before polarity
	always_comb begin
		if (ackf_q[0])
			// Ready low only while a strobe waits
			ack_level = !(strb && state_q != hsp_pkg::ST_HOLD); // RULE12
		else
			ack_level = strb && state_q == hsp_pkg::ST_HOLD; // RULE11
	end

	// Pin released until straps are taken so the host can drive them
	assign o_host_ack_ready_out = ack_level ^ ~pol_q; // RULE20
	assign o_host_ack_ready_oe = strap_done_q && cs;

	// Register reads, data in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				hsp_pkg::REG_CFG: begin
					o_reg_rdata <= {8'h00, ackf_q, pol_q, 3'h0, acc_q, wide_q}; // RULE7
				end
				hsp_pkg::REG_PAGE: begin
					o_reg_rdata <= {8'h00, page_q};
				end
				hsp_pkg::REG_STAT: begin
					o_reg_rdata <= {13'h0000, strap_done_q, state_q == hsp_pkg::ST_MEM, state_q != hsp_pkg::ST_IDLE};
				end
				default: begin
					o_reg_rdata <= 16'h0000;
				end
			endcase
		end else begin
			o_reg_rdata <= 16'h0000;
		end
	end
endmodule

// ==== tb/hsp_port_chk.sv ====
// Pin-level assertions for the host slave port
`timescale 1ns/1ps
module hsp_port_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	input wire logic i_ack_polarity_strap,
	input wire logic i_host_ack_ready_in,
	input wire logic o_host_ack_ready_out,
	input wire logic o_host_ack_ready_oe,
	input wire logic i_host_write_strobe_n,
	input wire logic i_host_read_strobe_n,
	input wire logic o_dma_req,
	input wire logic [23:0] o_dma_addr,
	input wire logic i_dma_done,
	input wire logic [3:0] o_mem_sel,
	input wire logic o_core_steal
);
	logic [1:0] ackf_q;
	logic ack_act;
	assign ack_act = o_host_ack_ready_oe && (o_host_ack_ready_out == i_ack_polarity_strap);
	// Mirror of the ack function field
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ackf_q <= {1'b0, i_ack_polarity_strap == i_host_ack_ready_in};
		else if (i_reg_wr && i_reg_addr == hsp_pkg::REG_CFG)
			ackf_q <= i_reg_wdata[7:6];
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_cfg_rd;
		i_reg_rd && i_reg_addr == hsp_pkg::REG_CFG;
	endsequence
	sequence s_mem_done;
		o_dma_req && i_dma_done;
	endsequence
	chk_ackf_readback: assert property (
		s_cfg_rd |=> o_reg_rdata[7:6] == $past(ackf_q)) else $error("ack function field wrong");
	chk_pol_readonly: assert property (
		s_cfg_rd |=> o_reg_rdata[5] == i_ack_polarity_strap) else $error("polarity bit wrong");
	chk_steal_internal: assert property (
		o_core_steal == (o_dma_req && i_dma_done && o_mem_sel[hsp_pkg::SEL_INT])) else $error("core steal wrong");
	chk_sel_onehot: assert property (
		o_dma_req |-> $onehot(o_mem_sel)) else $error("memory select not one-hot");
	chk_req_steady: assert property (
		o_dma_req && !i_dma_done |=> o_dma_req && $stable(o_dma_addr)) else $error("request dropped early");
	chk_no_early_ack: assert property (
		o_dma_req |-> !ack_act) else $error("ack while memory busy");
	chk_ack_after_done: assert property (
		s_mem_done |-> ##[1:2] ack_act) else $error("no ack after memory done");
	chk_ack_withdrawn: assert property (
		(!ackf_q[0] && i_host_write_strobe_n && i_host_read_strobe_n)[*8] |=> !ack_act) else $error("ack held");
endmodule

// ==== tb/hsp_host_model.sv ====
// Host model driving the multiplexed bus
`timescale 1ns/1ps
module hsp_host_model (
	input wire logic i_clk,
	input wire logic i_pol,
	input wire logic i_ack,
	input wire logic [15:0] i_ad,
	output logic [15:0] o_ad,
	output logic o_ale,
	output logic o_wr_n,
	output logic o_rd_n,
	output logic o_ms_n,
	output logic o_ios_n
);
	initial begin
		o_ad = 16'h0000;
		o_ale = 1'b0;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_ms_n = 1'b1;
		o_ios_n = 1'b1;
	end
	task automatic latch(input logic [15:0] a);
		@(posedge i_clk);
		o_ad <= a;
		o_ms_n <= 1'b0;
		o_ale <= 1'b1;
		repeat (6) @(posedge i_clk);
		o_ale <= 1'b0;
		repeat (6) @(posedge i_clk);
		o_ms_n <= 1'b1;
		o_ad <= ~a;
	endtask
	task automatic xfer(input logic we, input logic [15:0] d, output logic [15:0] q, output logic ok);
		int n;
		n = 0;
		@(posedge i_clk);
		o_ms_n <= 1'b0;
		o_ad <= we ? d : ~o_ad;
		o_wr_n <= !we;
		o_rd_n <= we;
		repeat (10) @(posedge i_clk);
		// Ack and data taken at the edge that releases the strobe
		while (i_ack !== i_pol && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		q = i_ad;
		ok = n < 200;
		o_wr_n <= 1'b1;
		o_rd_n <= 1'b1;
		o_ms_n <= 1'b1;
		o_ad <= ~o_ad;
		repeat (10) @(posedge i_clk);
	endtask
	// Address cycle: latch high together with the write strobe
	task automatic acyc(input logic [15:0] a, output logic ok);
		int n;
		n = 0;
		@(posedge i_clk);
		o_ad <= a;
		o_ms_n <= 1'b0;
		o_ale <= 1'b1;
		o_wr_n <= 1'b0;
		repeat (10) @(posedge i_clk);
		while (i_ack !== i_pol && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		ok = n < 200;
		o_ale <= 1'b0;
		o_wr_n <= 1'b1;
		o_ms_n <= 1'b1;
		repeat (10) @(posedge i_clk);
	endtask
endmodule

// ==== tb/tb_host_slave_port_ack_logic.sv ====
// Bench for the host slave port
`timescale 1ns/1ps
module tb_host_slave_port_ack_logic;
	typedef struct {logic [15:0] cfg; logic [7:0] page; logic [3:0] sel;} hsp_row_s;
	hsp_row_s rows[3] = '{'{16'h0041, 8'h00, 4'h1}, '{16'h0001, 8'h10, 4'h2}, '{16'h0001, 8'hf0, 4'h4}};
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_ack_polarity_strap = 1'b1, strap_lvl = 1'b1;
	logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_dma_done = 1'b0, ok, dwe_q;
	logic [3:0] i_reg_addr = 4'h0, sel_q;
	logic [15:0] i_reg_wdata = 16'h0000, host_ad, q, o_reg_rdata, o_host_ad, i_host_ad;
	logic [23:0] i_dma_rdata = 24'h3c5a69, o_dma_addr, o_dma_wdata, addr_q, wd_q;
	logic [1:0] cnt = 2'h0;
	logic [3:0] o_mem_sel;
	logic i_host_addr_latch_in, i_host_write_strobe_n, i_host_read_strobe_n, i_mem_space_select_n;
	logic i_io_space_select_n, i_host_ack_ready_in, o_host_ack_ready_out, o_host_ack_ready_oe;
	logic o_host_ad_oe, o_dma_req, o_dma_we, o_core_steal;
	int errors = 0;
	int num_checks = 0;
	assign i_host_ack_ready_in = o_host_ack_ready_oe ? o_host_ack_ready_out : strap_lvl;
	assign i_host_ad = o_host_ad_oe ? o_host_ad : host_ad;
	always #2 i_clk = ~i_clk;
	hsp_port i_hsp_port (.i_clk, .i_rst_n, .i_host_ad, .o_host_ad, .o_host_ad_oe, .i_host_addr_latch_in,
		.i_host_write_strobe_n, .i_host_read_strobe_n, .i_mem_space_select_n, .i_io_space_select_n,
		.i_ack_polarity_strap, .i_host_ack_ready_in, .o_host_ack_ready_out, .o_host_ack_ready_oe, .o_dma_req,
		.o_dma_we, .o_dma_addr, .o_dma_wdata, .o_mem_sel, .i_dma_done, .i_dma_rdata, .o_core_steal,
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
	hsp_host_model i_hsp_host_model (.i_clk, .i_pol(i_ack_polarity_strap), .i_ack(i_host_ack_ready_in),
		.i_ad(i_host_ad), .o_ad(host_ad), .o_ale(i_host_addr_latch_in), .o_wr_n(i_host_write_strobe_n),
		.o_rd_n(i_host_read_strobe_n), .o_ms_n(i_mem_space_select_n), .o_ios_n(i_io_space_select_n));
	// Memory answers four cycles after a request
	always @(posedge i_clk) begin
		i_dma_done <= o_dma_req && !i_dma_done && cnt == 2'h3;
		if (o_dma_req && !i_dma_done) begin
			cnt <= cnt + 2'h1;
			if (cnt == 2'h3) begin
				dwe_q <= o_dma_we;
				sel_q <= o_mem_sel;
				addr_q <= o_dma_addr;
				wd_q <= o_dma_wdata;
			end
		end
	end
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_io(input logic wr, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= wr;
		i_reg_rd <= !wr;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		#1;
	endtask
	task automatic hx(input logic we, input logic [15:0] d);
		i_hsp_host_model.xfer(we, d, q, ok);
		chk("ack", 24'(ok), 24'h1);
		if (ok !== 1'b1)
			close_out();
	endtask
	task automatic do_reset(input logic pol, input logic lvl, input logic [15:0] exp);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		i_ack_polarity_strap <= pol;
		strap_lvl <= lvl;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (12) @(posedge i_clk);
		reg_io(1'b0, hsp_pkg::REG_CFG, 16'h0000);
		chk("cfg reset", 24'(o_reg_rdata), 24'(exp));
	endtask
	initial begin
		repeat (50000) @(posedge i_clk);
		errors++;
		close_out();
	end
	initial begin
		do_reset(1'b0, 1'b0, 16'h0040);
		do_reset(1'b1, 1'b0, 16'h0020);
		do_reset(1'b1, 1'b1, 16'h0060);
		foreach (rows[i]) begin
			reg_io(1'b1, hsp_pkg::REG_CFG, rows[i].cfg);
			reg_io(1'b1, hsp_pkg::REG_PAGE, {8'h00, rows[i].page});
			if (i == 0)
				i_hsp_host_model.latch(16'h0100);
			hx(1'b1, 16'h1234 + 16'(i));
			hx(1'b1, 16'h00a0 + 16'(i));
			chk("sel", 24'(sel_q), 24'(rows[i].sel));
			chk("addr", addr_q, {rows[i].page, 16'h0100 + 16'(i)});
			chk("wdata", wd_q, {8'ha0 + 8'(i), 16'h1234 + 16'(i)});
			chk("we", 24'(dwe_q), 24'h1);
		end
		reg_io(1'b1, hsp_pkg::REG_CFG, 16'h0001);
		i_hsp_host_model.latch(16'h0200);
		hx(1'b0, 16'h0000);
		chk("read piece0", 24'(q), 24'h005a69);
		hx(1'b0, 16'h0000);
		chk("read piece1", 24'(q), 24'h00003c);
		chk("read addr", addr_q, 24'hf00200);
		chk("read we", 24'(dwe_q), 24'h0);
		reg_io(1'b0, 4'hc, 16'h0000);
		chk("unmapped", 24'(o_reg_rdata), 24'h0);
		reg_io(1'b1, hsp_pkg::REG_CFG, 16'h00c0);
		reg_io(1'b0, hsp_pkg::REG_CFG, 16'h0000);
		chk("cfg write", 24'(o_reg_rdata), 24'h0000e0);
		i_hsp_host_model.acyc(16'h0300, ok);
		chk("acc ack", 24'(ok), 24'h1);
		hx(1'b1, 16'h0011);
		hx(1'b1, 16'h0022);
		hx(1'b1, 16'h0033);
		chk("acc addr", addr_q, 24'hf00300);
		chk("acc sel", 24'(sel_q), 24'h4);
		chk("byte word", wd_q, 24'h332211);
		reg_io(1'b0, hsp_pkg::REG_CFG, 16'h0000);
		chk("acc bit", 24'(o_reg_rdata), 24'h0000e2);
		close_out();
	end
endmodule
bind hsp_port hsp_port_chk i_hsp_port_chk (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
	.o_reg_rdata, .i_ack_polarity_strap, .i_host_ack_ready_in, .o_host_ack_ready_out, .o_host_ack_ready_oe,
	.i_host_write_strobe_n, .i_host_read_strobe_n, .o_dma_req, .o_dma_addr, .i_dma_done, .o_mem_sel, .o_core_steal);
